// [hw/sdlc_lane_drive.sv]
// Picks the de-emphasis and equalization codes one lane's driver uses
module sdlc_lane_drive (
  // Lane settings and port mode
  input  wire sdlc_pkg::sdlc_txset_t set_i,
  input  wire logic                  gen2_i,
  input  wire logic                  deemph_level_choice_i,
  input  wire logic                  low_swing_i,
  // Gated result
  output sdlc_pkg::sdlc_drive_t      drv_o
);

  // Rate and de-emphasis choice pick the field; low swing disables it
  always_comb begin
    drv_o.deemph_en   = !low_swing_i;
    drv_o.eq_en       = !gen2_i && !deemph_level_choice_i && !low_swing_i;
    drv_o.eq_code     = set_i.eq_gen1;
    if (low_swing_i) begin
      drv_o.deemph_code = 2'h0;
    end else if (!gen2_i) begin
      drv_o.deemph_code = set_i.cd_gen1;
    end else if (!deemph_level_choice_i) begin
      drv_o.deemph_code = set_i.cd_gen2_low;
    end else begin
      drv_o.deemph_code = set_i.cd_gen2_high;
    end
  end

endmodule

// [hw/sdlc_lane_regs.sv]
// Strobed register access and the address map are this design's own decisions.
module sdlc_lane_regs (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  // Register port
  input  wire logic [7:0]             addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic [31:0]                 rdata_o,
  // Port mode from the link side (same clock)
  input  wire logic                   gen2_i,
  input  wire logic                   deemph_level_choice_i,
  input  wire logic                   low_swing_i,
  input  wire logic                   port_disabled_i,
  // SerDes power and training control
  output logic                        deep_low_o,
  output logic                        force_detect_o,
  output logic                        train_start_o,
  // Per-lane driver settings
  output sdlc_pkg::sdlc_drive_t [3:0] lane_drive_o
);

  // Register state of this module, all but the reset synchroniser
  typedef struct packed {
    logic [4:0]                 lane_target_select;
    logic                       serdes_power_off;
    logic [31:0]                txl0_shadow;
    sdlc_pkg::sdlc_txset_t [3:0] lane_set;
    logic [31:0]                rdata;
    logic                       deep_low;
    logic                       force_detect;
    logic                       train_start;
    sdlc_pkg::sdlc_drive_t [3:0] drive;
  } sdlc_state_t;

  sdlc_state_t s_reg;
  sdlc_state_t s_next;
  logic [1:0]  rst_sync_reg;
  logic        rst_n;

  logic                         pw_deep_low;
  logic                         pw_force_detect;
  logic                         pw_train_start;
  sdlc_pkg::sdlc_drive_t [3:0]  drv_comb;

  // Layout of transmitter lane control zero, reserved bits forced low
  function automatic logic [31:0] sdlc_txl0_pack(
    input sdlc_pkg::sdlc_txset_t s
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[sdlc_pkg::SDLC_CDG1_LSB +: 2] = s.cd_gen1;
    w[sdlc_pkg::SDLC_CDL_LSB  +: 2] = s.cd_gen2_low;
    w[sdlc_pkg::SDLC_CDH_LSB  +: 2] = s.cd_gen2_high;
    w[sdlc_pkg::SDLC_EQG1_LSB +: 2] = s.eq_gen1;
    return w;
  endfunction

  function automatic sdlc_pkg::sdlc_txset_t sdlc_txl0_unpack(
    input logic [31:0] w
  );
    sdlc_pkg::sdlc_txset_t s;
    s.cd_gen1      = w[sdlc_pkg::SDLC_CDG1_LSB +: 2];
    s.cd_gen2_low  = w[sdlc_pkg::SDLC_CDL_LSB  +: 2];
    s.cd_gen2_high = w[sdlc_pkg::SDLC_CDH_LSB  +: 2];
    s.eq_gen1      = w[sdlc_pkg::SDLC_EQG1_LSB +: 2];
    return s;
  endfunction

  // Does the selector aim a write at this lane
  function automatic logic sdlc_lane_hit(
    input logic [4:0] sel,
    input int         lane
  );
    return (sel == sdlc_pkg::SDLC_SEL_ALL) ||
           (sel <= sdlc_pkg::SDLC_SEL_LANE3 && sel[1:0] == lane[1:0]);
  endfunction

  // Reset release through two flops; kept apart as it has its own reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  sdlc_power_seq u_power (
    .clk_i              (clk_i),
    .rst_n_i            (rst_n),
    .serdes_power_off_i (s_reg.serdes_power_off),
    .other_off_i        (port_disabled_i),
    .deep_low_o         (pw_deep_low),
    .force_detect_o     (pw_force_detect),
    .train_start_o      (pw_train_start)
  );

  for (genvar g = 0; g < sdlc_pkg::SDLC_LANES; g++) begin : g_lane
    sdlc_lane_drive u_drive (
      .set_i                 (s_reg.lane_set[g]),
      .gen2_i                (gen2_i),
      .deemph_level_choice_i (deemph_level_choice_i),
      .low_swing_i           (low_swing_i),
      .drv_o                 (drv_comb[g])
    );
  end

  // Register writes, reads and output staging
  always_comb begin
    s_next          = s_reg;
    s_next.rdata    = 32'h0000_0000;
    if (wr_i && addr_i == sdlc_pkg::SDLC_OFS_SELPWR) begin
      // Reserved codes are stored as written; a lane-register write then reaches no lane
      s_next.lane_target_select =
        wdata_i[sdlc_pkg::SDLC_SEL_LSB +: 5];
      s_next.serdes_power_off = wdata_i[sdlc_pkg::SDLC_PWR_BIT];
    end
    if (wr_i && addr_i == sdlc_pkg::SDLC_OFS_TXL0) begin
      s_next.txl0_shadow =
        sdlc_txl0_pack(sdlc_txl0_unpack(wdata_i));
      for (int i = 0; i < sdlc_pkg::SDLC_LANES; i++) begin
        if (sdlc_lane_hit(s_reg.lane_target_select, i)) begin
          s_next.lane_set[i] = sdlc_txl0_unpack(wdata_i);
        end
      end
    end
    if (rd_i) begin
      case (addr_i)
        sdlc_pkg::SDLC_OFS_SELPWR: begin
          s_next.rdata[sdlc_pkg::SDLC_SEL_LSB +: 5] = s_reg.lane_target_select;
          s_next.rdata[sdlc_pkg::SDLC_PWR_BIT] = s_reg.serdes_power_off;
        end
        sdlc_pkg::SDLC_OFS_TXL0: begin
          s_next.rdata = s_reg.txl0_shadow;
        end
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    s_next.deep_low     = pw_deep_low;
    s_next.force_detect = pw_force_detect;
    s_next.train_start  = pw_train_start;
    s_next.drive        = drv_comb;
  end

  // Only the hard reset touches the settings: soft resets never reach here
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.lane_target_select <= sdlc_pkg::SDLC_RST_SEL;
      s_reg.serdes_power_off   <= sdlc_pkg::SDLC_RST_PWR;
      s_reg.txl0_shadow <= 32'h0000_0000 |
        {22'h0, sdlc_pkg::SDLC_RST_EQG1, 2'h0, sdlc_pkg::SDLC_RST_CDH,
         sdlc_pkg::SDLC_RST_CDL, sdlc_pkg::SDLC_RST_CDG1};
      for (int i = 0; i < sdlc_pkg::SDLC_LANES; i++) begin
        s_reg.lane_set[i] <= '{cd_gen1:      sdlc_pkg::SDLC_RST_CDG1,
                               cd_gen2_low:  sdlc_pkg::SDLC_RST_CDL,
                               cd_gen2_high: sdlc_pkg::SDLC_RST_CDH,
                               eq_gen1:      sdlc_pkg::SDLC_RST_EQG1};
      end
      s_reg.rdata        <= 32'h0000_0000;
      s_reg.deep_low     <= 1'b0;
      s_reg.force_detect <= 1'b0;
      s_reg.train_start  <= 1'b0;
      s_reg.drive        <= '0;
    end else begin
      s_reg.lane_target_select <= s_next.lane_target_select;
      s_reg.serdes_power_off   <= s_next.serdes_power_off;
      s_reg.txl0_shadow        <= s_next.txl0_shadow;
      s_reg.lane_set           <= s_next.lane_set;
      s_reg.rdata              <= s_next.rdata;
      s_reg.deep_low           <= s_next.deep_low;
      s_reg.force_detect       <= s_next.force_detect;
      s_reg.train_start        <= s_next.train_start;
      s_reg.drive              <= s_next.drive;
    end
  end

  assign rdata_o        = s_reg.rdata;
  assign deep_low_o     = s_reg.deep_low;
  assign force_detect_o = s_reg.force_detect;
  assign train_start_o  = s_reg.train_start;
  assign lane_drive_o   = s_reg.drive;

  property p_single_lane;
    @(posedge clk_i) disable iff (!rst_n)
      (wr_i && addr_i == sdlc_pkg::SDLC_OFS_TXL0 &&
       s_reg.lane_target_select == 5'h00)
        |=> s_reg.lane_set[1] == $past(s_reg.lane_set[1]) &&
            s_reg.lane_set[0] == sdlc_txl0_unpack($past(wdata_i));
  endproperty
  a_single_lane: assert property (p_single_lane)
    else $error("single-lane write hit wrong lane");

  property p_all_lanes;
    @(posedge clk_i) disable iff (!rst_n)
      (wr_i && addr_i == sdlc_pkg::SDLC_OFS_TXL0 &&
       s_reg.lane_target_select == sdlc_pkg::SDLC_SEL_ALL)
        |=> s_reg.lane_set[3] == sdlc_txl0_unpack($past(wdata_i)) &&
            s_reg.lane_set[2] == s_reg.lane_set[3];
  endproperty
  a_all_lanes: assert property (p_all_lanes)
    else $error("broadcast write missed a lane");

  property p_read_back;
    @(posedge clk_i) disable iff (!rst_n)
      (wr_i && addr_i == sdlc_pkg::SDLC_OFS_TXL0)
        ##1 (rd_i && addr_i == sdlc_pkg::SDLC_OFS_TXL0 && !wr_i)
        |=> rdata_o == ($past(wdata_i, 2) & 32'h0000_033F);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("lane register read-back wrong");

  property p_reserved_zero;
    @(posedge clk_i) disable iff (!rst_n)
      rd_i |=> rdata_o[31:10] == 22'h0 && rdata_o[7:6] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");

  property p_low_swing;
    @(posedge clk_i) disable iff (!rst_n)
      low_swing_i |=> !lane_drive_o[0].deemph_en &&
                      lane_drive_o[0].deemph_code == 2'h0;
  endproperty
  a_low_swing: assert property (p_low_swing)
    else $error("de-emphasis active in low swing");

  property p_gen1_code;
    @(posedge clk_i) disable iff (!rst_n)
      ($past(rst_n) && !low_swing_i && !gen2_i)
        |=> lane_drive_o[1].deemph_code == $past(s_reg.lane_set[1].cd_gen1);
  endproperty
  a_gen1_code: assert property (p_gen1_code)
    else $error("gen1 de-emphasis code wrong");

  property p_gen2_low;
    @(posedge clk_i) disable iff (!rst_n)
      (!low_swing_i && gen2_i && !deemph_level_choice_i)
        |=> lane_drive_o[2].deemph_code ==
            $past(s_reg.lane_set[2].cd_gen2_low);
  endproperty
  a_gen2_low: assert property (p_gen2_low)
    else $error("gen2 -3.5dB code wrong");

  property p_gen2_high;
    @(posedge clk_i) disable iff (!rst_n)
      (!low_swing_i && gen2_i && deemph_level_choice_i)
        |=> lane_drive_o[3].deemph_code ==
            $past(s_reg.lane_set[3].cd_gen2_high);
  endproperty
  a_gen2_high: assert property (p_gen2_high)
    else $error("gen2 -6.0dB code wrong");

  property p_single_lane3;
    @(posedge clk_i) disable iff (!rst_n)
      (wr_i && addr_i == sdlc_pkg::SDLC_OFS_TXL0 &&
       s_reg.lane_target_select == sdlc_pkg::SDLC_SEL_LANE3)
        |=> s_reg.lane_set[0] == $past(s_reg.lane_set[0]) &&
            s_reg.lane_set[3] == sdlc_txl0_unpack($past(wdata_i));
  endproperty
  a_single_lane3: assert property (p_single_lane3)
    else $error("lane 3 write hit wrong lane");

  // Only a lane-register write may move any lane's settings
  property p_hold_settings;
    @(posedge clk_i) disable iff (!rst_n)
      !(wr_i && addr_i == sdlc_pkg::SDLC_OFS_TXL0)
        |=> $stable(s_reg.lane_set);
  endproperty
  a_hold_settings: assert property (p_hold_settings)
    else $error("lane settings changed without a write");

  property p_detect_out;
    @(posedge clk_i) disable iff (!rst_n)
      (s_reg.serdes_power_off && !port_disabled_i) |=> force_detect_o;
  endproperty
  a_detect_out: assert property (p_detect_out)
    else $error("detect output not raised");

  property p_eq_gen1;
    @(posedge clk_i) disable iff (!rst_n)
      ($past(rst_n) && !low_swing_i && !gen2_i && !deemph_level_choice_i)
        |=> lane_drive_o[0].eq_en &&
            lane_drive_o[0].eq_code == $past(s_reg.lane_set[0].eq_gen1);
  endproperty
  a_eq_gen1: assert property (p_eq_gen1)
    else $error("gen1 equalization not applied");

endmodule

// [hw/sdlc_pkg.sv]
package sdlc_pkg;

  // Register word offsets on the plain register port
  localparam logic [7:0] SDLC_OFS_SELPWR = 8'h00;
  localparam logic [7:0] SDLC_OFS_TXL0   = 8'h04;

  // Lane selector codes
  localparam int         SDLC_LANES      = 4;
  localparam logic [4:0] SDLC_SEL_LANE3  = 5'h03;
  localparam logic [4:0] SDLC_SEL_ALL    = 5'h10;

  // Field positions in the lane-select / power register
  localparam int SDLC_SEL_LSB = 0;
  localparam int SDLC_PWR_BIT = 5;

  // Field positions in transmitter lane control zero
  localparam int SDLC_CDG1_LSB = 0;
  localparam int SDLC_CDL_LSB  = 2;
  localparam int SDLC_CDH_LSB  = 4;
  localparam int SDLC_EQG1_LSB = 8;

  // Values after reset
  localparam logic [4:0] SDLC_RST_SEL  = 5'h10;
  localparam logic       SDLC_RST_PWR  = 1'b0;
  localparam logic [1:0] SDLC_RST_CDG1 = 2'h3;
  localparam logic [1:0] SDLC_RST_CDL  = 2'h1;
  localparam logic [1:0] SDLC_RST_CDH  = 2'h3;
  localparam logic [1:0] SDLC_RST_EQG1 = 2'h2;

  // Cycles held in the power-up sequence before training starts
  localparam logic [3:0] SDLC_INIT_CYCLES = 4'h8;

  // Transmitter settings of one lane
  typedef struct packed {
    logic [1:0] cd_gen1;
    logic [1:0] cd_gen2_low;
    logic [1:0] cd_gen2_high;
    logic [1:0] eq_gen1;
  } sdlc_txset_t;

  // Settings that reach one lane's driver after mode gating
  typedef struct packed {
    logic       deemph_en;
    logic [1:0] deemph_code;
    logic       eq_en;
    logic [1:0] eq_code;
  } sdlc_drive_t;

  // Power sequencer states
  typedef enum logic [2:0] {
    SDLC_PW_ON   = 3'b001,
    SDLC_PW_OFF  = 3'b010,
    SDLC_PW_INIT = 3'b100
  } sdlc_pwst_t;

endpackage

// [hw/sdlc_power_seq.sv]
// Power-down, power-up and training release of the SerDes
module sdlc_power_seq (
  // Clock and synchronised reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic serdes_power_off_i,
  input  wire logic other_off_i,
  // Status
  output logic      deep_low_o,
  output logic      force_detect_o,
  output logic      train_start_o
);

  typedef struct packed {
    sdlc_pkg::sdlc_pwst_t st;
    logic [3:0]           cnt;
    logic                 start;
  } sdlc_pwstate_t;

  sdlc_pwstate_t s_reg;
  sdlc_pwstate_t s_next;

  // Bit acts only while nothing else holds the SerDes down
  always_comb begin
    s_next       = s_reg;
    s_next.start = 1'b0;
    case (s_reg.st)
      sdlc_pkg::SDLC_PW_ON: begin
        if (serdes_power_off_i && !other_off_i) begin
          s_next.st = sdlc_pkg::SDLC_PW_OFF;
        end
      end
      sdlc_pkg::SDLC_PW_OFF: begin
        if (!serdes_power_off_i || other_off_i) begin
          s_next.st  = sdlc_pkg::SDLC_PW_INIT;
          s_next.cnt = sdlc_pkg::SDLC_INIT_CYCLES;
        end
      end
      sdlc_pkg::SDLC_PW_INIT: begin
        if (serdes_power_off_i && !other_off_i) begin
          s_next.st = sdlc_pkg::SDLC_PW_OFF;
        end else if (s_reg.cnt == 4'h1) begin
          s_next.st    = sdlc_pkg::SDLC_PW_ON;
          s_next.start = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end
      end
      default: s_next.st = sdlc_pkg::SDLC_PW_ON;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '{st: sdlc_pkg::SDLC_PW_ON, cnt: 4'h0, start: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Detect is forced combinationally so no activity delays it
  assign deep_low_o     = (s_reg.st == sdlc_pkg::SDLC_PW_OFF);
  assign force_detect_o = deep_low_o ||
                          (serdes_power_off_i && !other_off_i);
  assign train_start_o  = s_reg.start;

  property p_off_in_one;
    @(posedge clk_i) disable iff (!rst_n_i)
      (s_reg.st == sdlc_pkg::SDLC_PW_ON && serdes_power_off_i
       && !other_off_i) |=> deep_low_o;
  endproperty
  a_off_in_one: assert property (p_off_in_one)
    else $error("power-down not entered");

  property p_detect_now;
    @(posedge clk_i) disable iff (!rst_n_i)
      (serdes_power_off_i && !other_off_i) |-> force_detect_o;
  endproperty
  a_detect_now: assert property (p_detect_now)
    else $error("detect not forced at once");

  property p_train_after_init;
    @(posedge clk_i) disable iff (!rst_n_i)
      (deep_low_o && !serdes_power_off_i)
        ##1 (!serdes_power_off_i || other_off_i) [*8]
        |=> train_start_o;
  endproperty
  a_train_after_init: assert property (p_train_after_init)
    else $error("training not started after init");

  property p_no_effect_other;
    @(posedge clk_i) disable iff (!rst_n_i)
      (other_off_i && s_reg.st != sdlc_pkg::SDLC_PW_OFF)
        |=> !deep_low_o;
  endproperty
  a_no_effect_other: assert property (p_no_effect_other)
    else $error("power bit acted while already off");

endmodule

// [tb/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and register port
  logic                        clk_i;
  logic                        rstn_i;
  logic [7:0]                  addr_i;
  logic [31:0]                 wdata_i;
  logic                        wr_i;
  logic                        rd_i;
  logic [31:0]                 rdata_o;
  // Port mode levels
  logic                        gen2_i;
  logic                        deemph_level_choice_i;
  logic                        low_swing_i;
  logic                        port_disabled_i;
  // Power status and lane outputs
  logic                        deep_low_o;
  logic                        force_detect_o;
  logic                        train_start_o;
  sdlc_pkg::sdlc_drive_t [3:0] lane_drive_o;
  // Bookkeeping and expected lane settings
  int                          fail_count;
  int                          num_checks;
  sdlc_pkg::sdlc_txset_t       lane_model [4];
  logic [31:0]                 last_txl0;

  sdlc_lane_regs sdlc_lane_regs_inst (
    .clk_i                 (clk_i),
    .rstn_i                (rstn_i),
    .addr_i                (addr_i),
    .wdata_i               (wdata_i),
    .wr_i                  (wr_i),
    .rd_i                  (rd_i),
    .rdata_o               (rdata_o),
    .gen2_i                (gen2_i),
    .deemph_level_choice_i (deemph_level_choice_i),
    .low_swing_i           (low_swing_i),
    .port_disabled_i       (port_disabled_i),
    .deep_low_o            (deep_low_o),
    .force_detect_o        (force_detect_o),
    .train_start_o         (train_start_o),
    .lane_drive_o          (lane_drive_o)
  );

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check32(string name, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic check_bit(string name, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %b seen %b", name, exp, got);
      fail_count++;
    end
  endtask

  // Codes are only compared while their enable is expected high
  task automatic check_drv(int lane, sdlc_pkg::sdlc_drive_t exp);
    logic [5:0] m;
    m = {1'b1, {2{exp.deemph_en}}, 1'b1, {2{exp.eq_en}}};
    num_checks++;
    if ((lane_drive_o[lane] & m) !== (exp & m)) begin
      $display("wrong value lane_drive_o[%0d] expected %h seen %h",
               lane, exp & m, lane_drive_o[lane]);
      fail_count++;
    end
  endtask

  // Bounded wait ran out
  task automatic timed_out();
    fail_count++;
    tally_and_finish();
  endtask

  function automatic sdlc_pkg::sdlc_txset_t to_set(logic [31:0] w);
    return '{w[1:0], w[3:2], w[5:4], w[9:8]};
  endfunction

  // Expected driver settings under the present port mode
  function automatic sdlc_pkg::sdlc_drive_t exp_drv(
    sdlc_pkg::sdlc_txset_t s);
    sdlc_pkg::sdlc_drive_t r;
    r.deemph_en   = !low_swing_i;
    r.deemph_code = !gen2_i ? s.cd_gen1 :
                    (deemph_level_choice_i ? s.cd_gen2_high : s.cd_gen2_low);
    r.eq_en       = !gen2_i && !deemph_level_choice_i && !low_swing_i;
    r.eq_code     = s.eq_gen1;
    return r;
  endfunction

  task automatic check_lanes();
    #1;
    for (int l = 0; l < sdlc_pkg::SDLC_LANES; l++) begin
      check_drv(l, exp_drv(lane_model[l]));
    end
  endtask

  task automatic reg_write(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic reg_read(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Write then read the same offset with no idle cycle between
  task automatic reg_write_read(logic [7:0] a, logic [31:0] wd,
                                output logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= wd;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    rd_i    <= 1'b1;
    @(posedge clk_i);
    rd_i    <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic t_reset_values();
    logic [31:0] d;
    reg_read(sdlc_pkg::SDLC_OFS_SELPWR, d);
    check32("selpwr reset", {27'h0, sdlc_pkg::SDLC_RST_SEL}, d);
    reg_read(sdlc_pkg::SDLC_OFS_TXL0, d);
    check32("txl0 reset", {22'h0, sdlc_pkg::SDLC_RST_EQG1, 2'h0,
            sdlc_pkg::SDLC_RST_CDH, sdlc_pkg::SDLC_RST_CDL,
            sdlc_pkg::SDLC_RST_CDG1}, d);
    check_lanes();
    check_bit("deep_low_o", 1'b0, deep_low_o);
  endtask

  // Distinct settings per lane, selector moved between writes
  task automatic t_lane_select();
    logic [31:0] v;
    logic [31:0] d;
    for (int l = 0; l <= int'(sdlc_pkg::SDLC_SEL_LANE3); l++) begin
      v = {22'h0, 2'(l), 2'h0, 2'(3 - l), 2'(l + 1), 2'(l)};
      reg_write(sdlc_pkg::SDLC_OFS_SELPWR, 32'(l));
      reg_write(sdlc_pkg::SDLC_OFS_TXL0, v);
      lane_model[l] = to_set(v);
      last_txl0 = v;
      repeat (3) @(posedge clk_i);
      check_lanes();
      reg_read(sdlc_pkg::SDLC_OFS_TXL0, d);
      check32("txl0 readback", v, d);
    end
    reg_write(sdlc_pkg::SDLC_OFS_SELPWR, 32'(sdlc_pkg::SDLC_SEL_ALL));
    reg_read(sdlc_pkg::SDLC_OFS_TXL0, d);
    check32("txl0 after select", last_txl0, d);
  endtask

  // Every mode combination against the per-lane settings
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_i);
      gen2_i                <= m[2];
      deemph_level_choice_i <= m[1];
      low_swing_i           <= m[0];
      repeat (3) @(posedge clk_i);
      check_lanes();
    end
    @(posedge clk_i);
    gen2_i                <= 1'b0;
    deemph_level_choice_i <= 1'b0;
    low_swing_i           <= 1'b0;
  endtask

  task automatic t_reserved();
    logic [31:0] d;
    reg_write(sdlc_pkg::SDLC_OFS_TXL0, 32'hFFFFFFFF);
    for (int l = 0; l < sdlc_pkg::SDLC_LANES; l++) begin
      lane_model[l] = to_set(32'hFFFFFFFF);
    end
    reg_read(sdlc_pkg::SDLC_OFS_TXL0, d);
    check32("txl0 reserved", 32'h0000033F, d);
    check_lanes();
    reg_write(sdlc_pkg::SDLC_OFS_SELPWR, 32'hFFFFFFD0);
    reg_read(sdlc_pkg::SDLC_OFS_SELPWR, d);
    check32("selpwr reserved", 32'h00000010, d);
    reg_write(8'h08, 32'h12345678);
    reg_read(8'h08, d);
    check32("unmapped read", 32'h00000000, d);
    reg_read(sdlc_pkg::SDLC_OFS_TXL0, d);
    check32("txl0 untouched", 32'h0000033F, d);
    reg_write_read(sdlc_pkg::SDLC_OFS_TXL0, 32'hFFFFFCC6, d);
    for (int l = 0; l < sdlc_pkg::SDLC_LANES; l++) begin
      lane_model[l] = to_set(32'h00000006);
    end
    check32("txl0 back to back", 32'h00000006, d);
    check_lanes();
  endtask

  task automatic t_power();
    int n;
    reg_write(sdlc_pkg::SDLC_OFS_SELPWR, 32'h00000030);
    n = 0;
    while (!(force_detect_o === 1'b1 && deep_low_o === 1'b1)) begin
      if (n == 4) timed_out();
      @(posedge clk_i);
      #1 n++;
    end
    check_bit("train_start_o off", 1'b0, train_start_o);
    check_bit("detect in time", 1'b1, n <= 2);
    reg_write(sdlc_pkg::SDLC_OFS_SELPWR, 32'h00000010);
    n = 0;
    while (train_start_o !== 1'b1) begin
      if (n == 40) timed_out();
      @(posedge clk_i);
      #1 n++;
    end
    check_bit("init wait", 1'b1, n >= 8);
    check_bit("deep_low_o up", 1'b0, deep_low_o);
    @(posedge clk_i);
    #1 check_bit("train_start_o pulse", 1'b0, train_start_o);
    check_lanes();
  endtask

  // Power bit toggled while the port already holds the SerDes off
  task automatic t_power_disabled();
    @(posedge clk_i);
    port_disabled_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reg_write(sdlc_pkg::SDLC_OFS_SELPWR, 32'h00000030);
    repeat (4) @(posedge clk_i);
    #1 check_bit("deep_low_o disabled", 1'b0, deep_low_o);
    check_bit("force_detect_o disabled", 1'b0, force_detect_o);
    reg_write(sdlc_pkg::SDLC_OFS_SELPWR, 32'h00000010);
    for (int i = 0; i < 30; i++) begin
      @(posedge clk_i);
      #1 if (train_start_o !== 1'b0) begin
        check_bit("train_start_o disabled", 1'b0, train_start_o);
      end
    end
    check_bit("train_start_o disabled", 1'b0, train_start_o);
    @(posedge clk_i);
    port_disabled_i <= 1'b0;
    repeat (30) @(posedge clk_i);
  endtask

  // Main sequence
  initial begin
    clk_i                 = 1'b0;
    rstn_i                = 1'b0;
    addr_i                = 8'h00;
    wdata_i               = 32'h00000000;
    wr_i                  = 1'b0;
    rd_i                  = 1'b0;
    gen2_i                = 1'b0;
    deemph_level_choice_i = 1'b0;
    low_swing_i           = 1'b0;
    port_disabled_i       = 1'b0;
    fail_count            = 0;
    num_checks            = 0;
    for (int l = 0; l < 4; l++) begin
      lane_model[l] = '{sdlc_pkg::SDLC_RST_CDG1, sdlc_pkg::SDLC_RST_CDL,
                        sdlc_pkg::SDLC_RST_CDH, sdlc_pkg::SDLC_RST_EQG1};
    end
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset_values();
    t_lane_select();
    t_modes();
    t_reserved();
    t_power();
    t_power_disabled();
    tally_and_finish();
  end
endmodule
